// ### rtl/csu_code_security_unit.sv
// Behaviour
// - Blocked reads return zero, never stall.
// - Secure zone blocks debug and peripheral access.
// - Protection level follows current program counter.
// - PC in zone's secure memory permits CPU.
// - PC in unsecure memory blocks everything secure.
// - Two communication zones, one control zone.
// - Claim registers assign RAM blocks and sectors.
// - Three sectors hard-wired to zones zero, one, two.
// - Each zone has four-word 128-bit password.
// - Password lives in zone's dedicated sector.
// - Unsecure only after successful password match or an all-ones password read.
// - All-ones password unsecures after plain read.
// - All-zero password keeps zone secure always.
// - All-zero password refuses match-sequence unlock.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "csu_map.svh"

module csu_code_security_unit #(
	parameter int NUM_RAM  = 8,
	parameter int NUM_SECT = 14,
	parameter int CTL_SECT = 1
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic [7:0]        regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic [31:0]            regRdData,
	input  wire logic              accValid,
	input  wire csu_pkg::csu_src_t accSrc,
	input  wire logic              accWrite,
	input  wire logic [31:0]       accAddr,
	input  wire logic [31:0]       accWrData,
	output logic                   accRdValid,
	output logic [31:0]            accRdData,
	output logic                   accBlocked,
	input  wire logic [31:0]       pcComm,
	input  wire logic [31:0]       pcCtl,
	output logic                   memValid,
	output logic                   memWrite,
	output logic [31:0]            memAddr,
	output logic [31:0]            memWrData,
	input  wire logic [31:0]       memRdData,
	output logic [2:0]             zoneSecure
);
	localparam int NZ = 3;

	////////////////////////////////////////////////////////////////////////

	logic [NZ*NUM_RAM-1:0]  ramClaim_ff;
	logic [NZ*NUM_SECT-1:0] sectClaim_ff;
	logic [NZ-1:0]          secure;
	logic [NZ-1:0]          relock_ff;
	logic                   blkSticky_ff;
	logic [31:0]            blkCnt_ff;
	logic [31:0]            nxt_regRdData;

	logic                   accOwned;
	csu_pkg::csu_zone_t     accZone;
	logic                   accPwd;
	logic [1:0]             accPwdWord;
	logic                   commOwned;
	csu_pkg::csu_zone_t     commZone;
	logic                   ctlOwned;
	csu_pkg::csu_zone_t     ctlZone;

	logic                   allow;
	logic                   blockNow;
	logic                   issue;

	logic                   rdPend_ff;
	logic                   rdBlk_ff;
	logic                   rdPwd_ff;
	csu_pkg::csu_zone_t     rdZone_ff;
	logic [1:0]             rdWord_ff;

	logic [1:0]             regZone;
	logic [4:0]             regSub;
	logic                   regInZone;

	assign regZone = regAddr[6:5];
	assign regSub = regAddr[4:0];
	assign regInZone = (regAddr < `CSU_OFF_CTRL);

	////////////////////////////////////////////////////////////////////////
	// Ownership lookup for the access and for both program counters.

	csu_zone_map #(
		.NUM_ZONES (NZ),
		.NUM_RAM   (NUM_RAM),
		.NUM_SECT  (NUM_SECT),
		.CTL_SECT  (CTL_SECT)
	) u_accMap (
		.addr      (accAddr),
		.ramClaim  (ramClaim_ff),
		.sectClaim (sectClaim_ff),
		.owned     (accOwned),
		.zone      (accZone),
		.pwdHit    (accPwd),
		.pwdWord   (accPwdWord)
	);

	csu_zone_map #(
		.NUM_ZONES (NZ),
		.NUM_RAM   (NUM_RAM),
		.NUM_SECT  (NUM_SECT),
		.CTL_SECT  (CTL_SECT)
	) u_commPcMap (
		.addr      (pcComm),
		.ramClaim  (ramClaim_ff),
		.sectClaim (sectClaim_ff),
		.owned     (commOwned),
		.zone      (commZone),
		.pwdHit    (),
		.pwdWord   ()
	);

	csu_zone_map #(
		.NUM_ZONES (NZ),
		.NUM_RAM   (NUM_RAM),
		.NUM_SECT  (NUM_SECT),
		.CTL_SECT  (CTL_SECT)
	) u_ctlPcMap (
		.addr      (pcCtl),
		.ramClaim  (ramClaim_ff),
		.sectClaim (sectClaim_ff),
		.owned     (ctlOwned),
		.zone      (ctlZone),
		.pwdHit    (),
		.pwdWord   ()
	);

	////////////////////////////////////////////////////////////////////////
	// One password lock per zone.

	for (genvar z = 0; z < NZ; z++) begin : g_zone
		logic keyWr;
		logic pwdCap;

		assign keyWr = regWr && regInZone && (regZone == 2'(z))
			&& (regSub < 5'(`CSU_OFF_RAMCLAIM));
		assign pwdCap = rdPend_ff && rdPwd_ff && (rdZone_ff == 2'(z));

		csu_zone_lock u_lock (
			.sys_clk (sys_clk),
			.sys_rst (sys_rst),
			.keyWr   (keyWr),
			.keyIdx  (regSub[3:2]),
			.keyData (regWrData),
			.pwdCap  (pwdCap),
			.pwdIdx  (rdWord_ff),
			.pwdData (memRdData),
			.relock  (relock_ff[z]),
			.secure  (secure[z])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Access decision. The program counter is looked at in the same cycle
	// as the access, so a jump into or out of secure code takes effect on
	// the very next access without any flush.

	always_comb begin
		allow = 1'b1;
		if (accOwned && secure[accZone]) begin
			case (accSrc)
				csu_pkg::SRC_CPU_COMM: begin
					allow = commOwned && (commZone == accZone)
						&& (accZone != 2'h2);
				end
				csu_pkg::SRC_CPU_CTL: begin
					allow = ctlOwned && (ctlZone == accZone)
						&& (accZone == 2'h2);
				end
				csu_pkg::SRC_DEBUG: begin
					allow = 1'b0;
				end
				csu_pkg::SRC_PERIPH: begin
					allow = 1'b0;
				end
				default: begin
					allow = 1'b0;
				end
			endcase
		end
	end

	assign blockNow = accValid && !allow;

	// Password words are fetched even from a secure zone so that the lock
	// sees them, but the requester still gets zero back.
	assign issue = accValid && (allow || (accPwd && !accWrite));

	////////////////////////////////////////////////////////////////////////
	// Memory request stage.

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			memValid <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= `CSU_RST_WORD;
			memWrData <= `CSU_RST_WORD;
		end else begin
			memValid <= issue;
			memWrite <= accValid && accWrite && allow;
			memAddr <= accAddr;
			memWrData <= accWrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdPend_ff <= 1'b0;
			rdBlk_ff <= 1'b0;
			rdPwd_ff <= 1'b0;
			rdZone_ff <= 2'h0;
			rdWord_ff <= 2'h0;
		end else begin
			rdPend_ff <= accValid && !accWrite;
			rdBlk_ff <= !allow;
			rdPwd_ff <= accPwd && !accWrite;
			rdZone_ff <= accZone;
			rdWord_ff <= accPwdWord;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read answer stage: memory data arrive in the same cycle as the request.

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			accRdValid <= 1'b0;
			accRdData <= `CSU_RST_WORD;
		end else begin
			accRdValid <= rdPend_ff;
			if (rdPend_ff && !rdBlk_ff) begin
				accRdData <= memRdData;
			end else begin
				accRdData <= `CSU_RST_WORD;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			accBlocked <= 1'b0;
		end else begin
			accBlocked <= blockNow;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			zoneSecure <= 3'h7;
		end else begin
			zoneSecure <= secure;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file. Claims of a zone may only change while that zone is
	// unsecure; a lower-numbered unsecure zone claiming the same unit still takes it over.

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ramClaim_ff <= '0;
			sectClaim_ff <= '0;
		end else if (regWr && regInZone && regZone < 2'(NZ)
				&& !secure[regZone]) begin
			if (regSub == 5'(`CSU_OFF_RAMCLAIM)) begin
				ramClaim_ff[regZone*NUM_RAM +: NUM_RAM] <=
					regWrData[NUM_RAM-1:0];
			end
			if (regSub == 5'(`CSU_OFF_SECTCLAIM)) begin
				sectClaim_ff[regZone*NUM_SECT +: NUM_SECT] <=
					regWrData[NUM_SECT-1:0];
			end
		end
	end

	// Writing a one to a zone bit of the control register secures it again.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			relock_ff <= '0;
		end else if (regWr && regAddr == `CSU_OFF_CTRL) begin
			relock_ff <= regWrData[NZ-1:0];
		end else begin
			relock_ff <= '0;
		end
	end

	// A new block in the clearing cycle keeps the flag set.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			blkSticky_ff <= 1'b0;
		end else if (blockNow) begin
			blkSticky_ff <= 1'b1;
		end else if (regWr && regAddr == `CSU_OFF_CTRL
				&& regWrData[`CSU_CTRL_CLR_BIT]) begin
			blkSticky_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			blkCnt_ff <= `CSU_RST_WORD;
		end else if (blockNow && blkCnt_ff != `CSU_RST_ONES) begin
			blkCnt_ff <= blkCnt_ff + 32'h0000_0001;
		end
	end

	// Key words read back as zero so the password cannot be probed.
	always_comb begin
		nxt_regRdData = `CSU_RST_WORD;
		if (regInZone && regZone < 2'(NZ)) begin
			if (regSub == 5'(`CSU_OFF_RAMCLAIM)) begin
				nxt_regRdData[NUM_RAM-1:0] =
					ramClaim_ff[regZone*NUM_RAM +: NUM_RAM];
			end else if (regSub == 5'(`CSU_OFF_SECTCLAIM)) begin
				nxt_regRdData[NUM_SECT-1:0] =
					sectClaim_ff[regZone*NUM_SECT +: NUM_SECT];
			end
		end else if (regAddr == `CSU_OFF_STATUS) begin
			nxt_regRdData[NZ-1:0] = secure;
			nxt_regRdData[`CSU_STAT_BLK_BIT] = blkSticky_ff;
		end else if (regAddr == `CSU_OFF_BLKCNT) begin
			nxt_regRdData = blkCnt_ff;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regRdData <= `CSU_RST_WORD;
		end else if (regRd) begin
			regRdData <= nxt_regRdData;
		end else begin
			regRdData <= `CSU_RST_WORD;
		end
	end

endmodule
`default_nettype wire

// ### rtl/csu_map.svh
`ifndef CSU_MAP_SVH
`define CSU_MAP_SVH

// Register offsets, byte addresses on the 8-bit register port.
`define CSU_ZONE_STRIDE   8'h20
`define CSU_OFF_KEY0      8'h00
`define CSU_OFF_RAMCLAIM  8'h10
`define CSU_OFF_SECTCLAIM 8'h14
`define CSU_OFF_CTRL      8'h60
`define CSU_OFF_STATUS    8'h64
`define CSU_OFF_BLKCNT    8'h68

// Field positions.
`define CSU_STAT_BLK_BIT  8
`define CSU_CTRL_CLR_BIT  8

// Reset values.
`define CSU_RST_WORD      32'h0000_0000
`define CSU_RST_ONES      32'hFFFF_FFFF

// Memory map of the guarded memories.
`define CSU_RAM_BASE      32'h2000_0000
`define CSU_RAM_SHIFT     12
`define CSU_FLASH_BASE    32'h0020_0000
`define CSU_SECT_SHIFT    14
`define CSU_PWD_LINE      10'h3FF

`endif

// ### rtl/csu_pkg.sv
package csu_pkg;

	typedef enum logic [1:0] {
		SRC_CPU_COMM,
		SRC_CPU_CTL,
		SRC_DEBUG,
		SRC_PERIPH
	} csu_src_t;

	typedef logic [1:0] csu_zone_t;

	typedef logic [31:0] csu_word_t;

endpackage

// ### rtl/csu_zone_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "csu_map.svh"

module csu_zone_map #(
	parameter int NUM_ZONES = 3,
	parameter int NUM_RAM   = 8,
	parameter int NUM_SECT  = 14,
	parameter int CTL_SECT  = 1
) (
	input  wire logic [31:0]                   addr,
	input  wire logic [NUM_ZONES*NUM_RAM-1:0]  ramClaim,
	input  wire logic [NUM_ZONES*NUM_SECT-1:0] sectClaim,
	output logic                               owned,
	output csu_pkg::csu_zone_t                 zone,
	output logic                               pwdHit,
	output logic [1:0]                         pwdWord
);
	localparam int RW = 32 - `CSU_RAM_SHIFT;
	localparam int SW = 32 - `CSU_SECT_SHIFT;
	localparam logic [RW-1:0] RAM_LIM = RW'(NUM_RAM);
	localparam logic [SW-1:0] SECT_LIM = SW'(NUM_SECT);

	logic [31:0] ramOff;
	logic [31:0] sectOff;
	logic [RW-1:0] ramIdx;
	logic [SW-1:0] sectIdx;

	assign ramOff = addr - `CSU_RAM_BASE;
	assign sectOff = addr - `CSU_FLASH_BASE;
	assign ramIdx = ramOff[31:`CSU_RAM_SHIFT];
	assign sectIdx = sectOff[31:`CSU_SECT_SHIFT];
	assign pwdWord = addr[3:2];

	// Lowest zone number wins when two zones claim the same unit.
	always_comb begin
		owned = 1'b0;
		zone = 2'h0;
		pwdHit = 1'b0;
		if (ramIdx < RAM_LIM) begin
			for (int z = NUM_ZONES - 1; z >= 0; z--) begin
				if (ramClaim[z*NUM_RAM + int'(ramIdx)]) begin
					owned = 1'b1;
					zone = 2'(z);
				end
			end
		end else if (sectIdx < SECT_LIM) begin
			for (int z = NUM_ZONES - 1; z >= 0; z--) begin
				if (sectClaim[z*NUM_SECT + int'(sectIdx)]) begin
					owned = 1'b1;
					zone = 2'(z);
				end
			end
			if (int'(sectIdx) == NUM_SECT - 1) begin
				owned = 1'b1;
				zone = 2'h0;
			end else if (sectIdx == '0) begin
				owned = 1'b1;
				zone = 2'h1;
			end else if (int'(sectIdx) == CTL_SECT) begin
				owned = 1'b1;
				zone = 2'h2;
			end
			// Passwords sit in the top 16 bytes of the dedicated sector.
			pwdHit = owned && (sectOff[`CSU_SECT_SHIFT-1:4] == `CSU_PWD_LINE)
				&& (int'(sectIdx) == NUM_SECT - 1 || sectIdx == '0
				|| int'(sectIdx) == CTL_SECT);
		end
	end

endmodule
`default_nettype wire

// ### rtl/csu_zone_lock.sv
`timescale 1ns/1ps
`default_nettype none
`include "csu_map.svh"

module csu_zone_lock (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        keyWr,
	input  wire logic [1:0]  keyIdx,
	input  wire logic [31:0] keyData,
	input  wire logic        pwdCap,
	input  wire logic [1:0]  pwdIdx,
	input  wire logic [31:0] pwdData,
	input  wire logic        relock,
	output logic             secure
);
	logic [31:0] key_ff [4];
	logic [31:0] pwd_ff [4];
	logic [3:0]  have_ff;
	logic        unsec_ff;
	logic        allOnes;
	logic        allZero;
	logic        match;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				key_ff[i] <= `CSU_RST_WORD;
			end
		end else if (keyWr) begin
			key_ff[keyIdx] <= keyData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || relock) begin
			have_ff <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				pwd_ff[i] <= `CSU_RST_WORD;
			end
		end else if (pwdCap) begin
			pwd_ff[pwdIdx] <= pwdData;
			have_ff[pwdIdx] <= 1'b1;
		end
	end

	always_comb begin
		allOnes = 1'b1;
		allZero = 1'b1;
		match = 1'b1;
		for (int i = 0; i < 4; i++) begin
			allOnes = allOnes && (pwd_ff[i] == `CSU_RST_ONES);
			allZero = allZero && (pwd_ff[i] == `CSU_RST_WORD);
			match = match && (pwd_ff[i] == key_ff[i]);
		end
	end

	// A zone comes out of reset secure and only a complete password read
	// can release it; an all-zero password never releases it on a key match.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || relock) begin
			unsec_ff <= 1'b0;
		end else if (have_ff == 4'hF && allOnes) begin
			unsec_ff <= 1'b1;
		end else if (have_ff == 4'hF && match && !allZero) begin
			unsec_ff <= 1'b1;
		end
	end

	assign secure = !unsec_ff;

endmodule
`default_nettype wire

// ### test/csu_code_security_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module csu_code_security_unit_chk #(
	parameter int NUM_RAM  = 8,
	parameter int NUM_SECT = 14,
	parameter int CTL_SECT = 1
) (
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              regWr,
	input wire logic              accValid,
	input wire csu_pkg::csu_src_t accSrc,
	input wire logic              accWrite,
	input wire logic [31:0]       accAddr,
	input wire logic [31:0]       accWrData,
	input wire logic              accRdValid,
	input wire logic [31:0]       accRdData,
	input wire logic              accBlocked,
	input wire logic [31:0]       pcComm,
	input wire logic [31:0]       pcCtl,
	input wire logic              memValid,
	input wire logic              memWrite,
	input wire logic [31:0]       memAddr,
	input wire logic [31:0]       memWrData,
	input wire logic [2:0]        zoneSecure
);
	// Sector 0 belongs to zone 1 whatever the claims say, so it is a safe probe.
	logic hitS0;
	logic pcS0;
	logic pcIn2;
	assign hitS0 = accAddr[31:14] == 18'h00080;
	assign pcS0  = pcComm[31:14] == 18'h00080;
	assign pcIn2 = pcCtl[31:14] == 18'(18'h00080 + CTL_SECT);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	a_rd_answer:
	assert property (accValid && !accWrite |-> ##2 accRdValid)
	else $error("read not answered in two cycles");
	a_blk_zero:
	assert property (accValid && !accWrite ##1 accBlocked |=> accRdData == 32'h0)
	else $error("blocked read returned data");
	a_wr_drop:
	assert property (accValid && accWrite ##1 accBlocked |-> !memValid && !memWrite)
	else $error("blocked write reached memory");
	a_dbg_block:
	assert property (accValid && accSrc == csu_pkg::SRC_DEBUG && zoneSecure[1]
		&& hitS0 |=> accBlocked)
	else $error("debug access to secure zone passed");
	a_pc_out:
	assert property (accValid && accSrc == csu_pkg::SRC_CPU_COMM && zoneSecure[1]
		&& hitS0 && pcComm < 32'h0020_0000 |=> accBlocked)
	else $error("access from unsecure code passed");
	a_pc_in:
	assert property (accValid && accSrc == csu_pkg::SRC_CPU_COMM && pcS0 && hitS0
		|=> memValid && !accBlocked)
	else $error("secure code refused own data");
	a_ctl_side:
	assert property (accValid && accSrc == csu_pkg::SRC_CPU_CTL && pcIn2
		&& zoneSecure[1] && hitS0 |=> accBlocked)
	else $error("control code reached comm zone");
	a_zone_rise:
	assert property ($rose(zoneSecure[0]) |-> $past(regWr, 3))
	else $error("zone re-secured without a write");
	a_mem_copy:
	assert property (accValid && accWrite |=> memAddr == $past(accAddr)
		&& memWrData == $past(accWrData))
	else $error("write address or data not passed to memory");
	c_blk_read: cover property (accValid && !accWrite ##1 accBlocked);
	c_unlock: cover property ($fell(zoneSecure[0]));
	c_mem_wr: cover property (memWrite);
endmodule
bind csu_code_security_unit csu_code_security_unit_chk #(.NUM_RAM(NUM_RAM),
	.NUM_SECT(NUM_SECT), .CTL_SECT(CTL_SECT)) chk_u (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .regWr(regWr), .accValid(accValid), .accSrc(accSrc),
	.accWrite(accWrite), .accAddr(accAddr), .accRdValid(accRdValid),
	.accWrData(accWrData), .memAddr(memAddr), .memWrData(memWrData),
	.accRdData(accRdData), .accBlocked(accBlocked), .pcComm(pcComm),
	.pcCtl(pcCtl), .memValid(memValid), .memWrite(memWrite),
	.zoneSecure(zoneSecure));
`default_nettype wire

// ### test/csu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module csu_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        memValid,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	output logic [31:0]      memRdData
);
	logic [31:0] word;
	logic [31:0] rd = 32'h0;
	always_comb begin
		word = ~memAddr;
		if (memAddr[13:4] == 10'h3FF) begin
			case (memAddr[31:14])
				18'h0008D: word = 32'hFFFF_FFFF;
				18'h00080: word = 32'hC0DE_0000 | {28'h0, memAddr[3:0]};
				18'h00081: word = 32'h0;
				default: ;
			endcase
		end
	end
	// The word answers in the cycle the request stands, since the unit takes it
	// at the closing edge; between answers the data wanders.
	always_ff @(posedge sys_clk)
		rd <= ~rd;
	assign memRdData = (memValid && !memWrite) ? word : rd;
endmodule
`default_nettype wire

// ### test/test_csu_code_security_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_csu_code_security_unit;
	localparam csu_pkg::csu_src_t COM = csu_pkg::SRC_CPU_COMM;
	localparam csu_pkg::csu_src_t CTL = csu_pkg::SRC_CPU_CTL;
	localparam csu_pkg::csu_src_t DBG = csu_pkg::SRC_DEBUG;
	localparam csu_pkg::csu_src_t PER = csu_pkg::SRC_PERIPH;
	localparam logic [31:0] S0 = 32'h0020_0000, S1 = 32'h0020_4000;
	localparam logic [31:0] S13 = 32'h0023_4000, RAM = 32'h2000_0000;
	logic              sys_clk, sys_rst, regWr, regRd, accValid, accWrite;
	logic              accRdValid, accBlocked, memValid, memWrite, rdPend;
	logic [7:0]        regAddr;
	logic [31:0]       regWrData, regRdData, accAddr, accWrData, accRdData;
	logic [31:0]       pcComm, pcCtl, memAddr, memWrData, memRdData, rnd, a;
	logic [2:0]        zoneSecure;
	csu_pkg::csu_src_t accSrc;
	logic [31:0]       accQ[$], regQ[$];
	int                failures, compares;
	csu_code_security_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .accValid(accValid), .accSrc(accSrc),
		.accWrite(accWrite), .accAddr(accAddr), .accWrData(accWrData),
		.accRdValid(accRdValid), .accRdData(accRdData), .accBlocked(accBlocked),
		.pcComm(pcComm), .pcCtl(pcCtl), .memValid(memValid), .memWrite(memWrite),
		.memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
		.zoneSecure(zoneSecure));
	csu_mem_model mem_u (.sys_clk(sys_clk), .memValid(memValid),
		.memWrite(memWrite), .memAddr(memAddr), .memRdData(memRdData));
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// A read carries its expected value in d.
	task automatic rg(input logic w, input logic [7:0] ad, input logic [31:0] d);
		accValid <= 1'b0;
		regWr <= w;
		regRd <= !w;
		regAddr <= ad;
		regWrData <= d;
		if (!w)
			regQ.push_back(d);
		@(posedge sys_clk);
	endtask
	task automatic ac(input csu_pkg::csu_src_t s, input logic w,
		input logic [31:0] ad, input logic [31:0] e);
		regWr <= 1'b0;
		regRd <= 1'b0;
		accValid <= 1'b1;
		accSrc <= s;
		accWrite <= w;
		accAddr <= ad;
		accWrData <= rnd;
		if (!w)
			accQ.push_back(e);
		rnd = lfsr(rnd);
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		regWr <= 1'b0;
		regRd <= 1'b0;
		accValid <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic pwds(input logic [31:0] b);
		for (int w = 0; w < 4; w++)
			ac(DBG, 1'b0, b + 32'h3FF0 + 32'(4 * w), 32'h0);
		idle(4);
	endtask
	task automatic summarize;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) rdPend <= regRd;
	always @(negedge sys_clk) begin
		if (rdPend === 1'b1 && regQ.size() > 0)
			check(regRdData, regQ.pop_front());
		if (accRdValid === 1'b1 && accQ.size() > 0)
			check(accRdData, accQ.pop_front());
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		summarize();
	end
	initial begin
		{sys_rst, regWr, regRd, accValid, accWrite} = 5'h10;
		{regAddr, regWrData, accAddr, accWrData} = '0;
		accSrc = COM;
		pcComm = 32'h0000_1000;
		pcCtl = 32'h0000_1000;
		rnd = 32'h0001_07EC;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rg(0, 8'h64, 32'h0000_0007);
		rg(0, 8'h7C, 32'h0);
		rg(0, 8'h20, 32'h0);
		ac(DBG, 0, S0, 32'h0);
		ac(PER, 0, S0 + 32'h40, 32'h0);
		ac(DBG, 1, S0, 32'h0);
		ac(COM, 0, S0 + 32'h8, 32'h0);
		pcComm <= S0 + 32'h100;
		ac(COM, 0, S0 + 32'h8, ~(S0 + 32'h8));
		ac(DBG, 0, S0 + 32'h8, 32'h0);
		ac(COM, 0, S1, 32'h0);
		pcComm <= S13;
		ac(COM, 0, S0, 32'h0);
		ac(COM, 0, S13 + 32'h4, ~(S13 + 32'h4));
		pcComm <= 32'h0000_1000;
		ac(COM, 0, S13 + 32'h4, 32'h0);
		pcCtl <= S1 + 32'h20;
		ac(CTL, 0, S1 + 32'h4, ~(S1 + 32'h4));
		ac(CTL, 0, S0, 32'h0);
		idle(3);
		rg(0, 8'h64, 32'h0000_0107);
		rg(1, 8'h60, 32'h0000_0100);
		rg(0, 8'h64, 32'h0000_0007);
		pwds(S13);
		rg(0, 8'h64, 32'h0000_0106);
		ac(DBG, 0, S13 + 32'h4, ~(S13 + 32'h4));
		rg(1, 8'h14, 32'h0000_0001);
		rg(1, 8'h10, 32'h0000_0008);
		rg(1, 8'h50, 32'h0000_0020);
		rg(0, 8'h10, 32'h0000_0008);
		rg(0, 8'h50, 32'h0);
		ac(DBG, 0, S0 + 32'h4, 32'h0);
		ac(DBG, 0, RAM + 32'h3000, ~(RAM + 32'h3000));
		rg(1, 8'h60, 32'h0000_0001);
		idle(2);
		ac(DBG, 0, RAM + 32'h3000, 32'h0);
		// Zero keys equal a zero password, the case most likely to slip through.
		for (int w = 0; w < 4; w++)
			rg(1, 8'h40 + 8'(4 * w), 32'h0);
		pwds(S1);
		for (int w = 0; w < 4; w++)
			rg(1, 8'h20 + 8'(4 * w), 32'h0BAD_0000);
		pwds(S0);
		rg(0, 8'h64, 32'h0000_0107);
		for (int w = 0; w < 4; w++)
			rg(1, 8'h20 + 8'(4 * w), 32'hC0DE_0000 | 32'(4 * w));
		idle(3);
		rg(0, 8'h64, 32'h0000_0105);
		ac(DBG, 0, S0 + 32'h8, ~(S0 + 32'h8));
		for (int i = 0; i < 8; i++) begin
			a = RAM + 32'h5000 + {20'h0, rnd[11:2], 2'b00};
			ac(COM, i[0], a, ~a);
		end
		idle(4);
		for (int i = 0; i < 16 && accQ.size() + regQ.size() > 0; i++)
			@(posedge sys_clk);
		if (accQ.size() + regQ.size() > 0)
			failures++;
		summarize();
	end
endmodule
`default_nettype wire
